// file: logic/ieps_pkg.sv
package ieps_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 16;
    localparam logic [7:0]  OFF_ENABLE    = 8'h00;
    localparam logic [7:0]  OFF_PRIORITY  = 8'h04;
    localparam logic [7:0]  OFF_STATUS    = 8'h08;
    localparam logic [7:0]  OFF_MASK      = 8'h0C;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int          BIT_CAL_EN    = 14;
    localparam int          BIT_COL_EN    = 2;
    localparam int          BIT_EVT_EN    = 1;
    localparam int          PRIO_LSB      = 8;
    localparam int          PRIO_W        = 3;
    localparam logic [15:0] ENABLE_IMPL   = 16'h4006;
    localparam logic [15:0] PRIORITY_IMPL = 16'h0700;
    localparam logic [15:0] EVENT_IMPL    = 16'h4006;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ENABLE_RST    = 16'h0000;
    localparam logic [15:0] PRIORITY_RST  = 16'h0400;
    localparam logic [15:0] EVENT_RST     = 16'h0000;
    localparam logic [2:0]  PRIO_OFF      = 3'h0;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic calendar;
        logic collision;
        logic serial_event;
    } ieps_src_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [3:0]        strb;
    } ieps_wr_t;

endpackage : ieps_pkg

// file: logic/ieps_gate.sv
`timescale 1ns/1ps
`default_nettype none

module ieps_gate (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire ieps_pkg::ieps_src_t     src_i,
    input  wire logic [15:0]             enable_i,
    input  wire logic [2:0]              cal_prio_i,
    output var  ieps_pkg::ieps_src_t     req_o,
    output logic      [2:0]              cal_prio_o
);

    // ------------------------------------------------------------
    // Gating toward arbitration
    // ------------------------------------------------------------
    ieps_pkg::ieps_src_t gated;

    assign gated.calendar     = src_i.calendar && enable_i[ieps_pkg::BIT_CAL_EN]
                                && (cal_prio_i != ieps_pkg::PRIO_OFF);
    assign gated.collision    = src_i.collision && enable_i[ieps_pkg::BIT_COL_EN];
    assign gated.serial_event = src_i.serial_event && enable_i[ieps_pkg::BIT_EVT_EN];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_o      <= '0;
            cal_prio_o <= ieps_pkg::PRIORITY_RST[ieps_pkg::PRIO_LSB +: ieps_pkg::PRIO_W];
        end else begin
            req_o      <= gated;
            cal_prio_o <= cal_prio_i;
        end
    end

endmodule : ieps_gate

`default_nettype wire

// file: logic/ieps_top.sv
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ieps_top #(
    parameter int ADDR_W = ieps_pkg::ADDR_W
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic [ADDR_W-1:0]       s_axi_awaddr_i,
    input  wire logic                    s_axi_awvalid_i,
    output logic                         s_axi_awready_o,
    input  wire logic [31:0]             s_axi_wdata_i,
    input  wire logic [3:0]              s_axi_wstrb_i,
    input  wire logic                    s_axi_wvalid_i,
    output logic                         s_axi_wready_o,
    output logic      [1:0]              s_axi_bresp_o,
    output logic                         s_axi_bvalid_o,
    input  wire logic                    s_axi_bready_i,
    input  wire logic [ADDR_W-1:0]       s_axi_araddr_i,
    input  wire logic                    s_axi_arvalid_i,
    output logic                         s_axi_arready_o,
    output logic      [31:0]             s_axi_rdata_o,
    output logic      [1:0]              s_axi_rresp_o,
    output logic                         s_axi_rvalid_o,
    input  wire logic                    s_axi_rready_i,
    input  wire ieps_pkg::ieps_src_t     src_req_i,
    output var  ieps_pkg::ieps_src_t     arb_req_o,
    output logic      [2:0]              calendar_irq_priority_o,
    output logic                         calendar_irq_enable_o,
    output logic                         serial_collision_irq_enable_o,
    output logic                         serial_event_irq_enable_o,
    output logic                         irq_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge_strb(
        input logic [15:0] old_v,
        input logic [31:0] wdata,
        input logic [3:0]  strb,
        input logic [15:0] impl
    );
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}};
        merge_strb = ((old_v & ~lane) | (wdata[15:0] & lane)) & impl;
    endfunction : merge_strb

    function automatic logic [15:0] w1c_mask(
        input logic [31:0] wdata,
        input logic [3:0]  strb
    );
        w1c_mask = wdata[15:0] & {{8{strb[1]}}, {8{strb[0]}}};
    endfunction : w1c_mask

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0]          irq_enable_reg_three_r;
    logic [15:0]          irq_enable_reg_three_nxt;
    logic [15:0]          irq_priority_reg_fifteen_r;
    logic [15:0]          irq_priority_reg_fifteen_nxt;
    logic [15:0]          event_status_r;
    logic [15:0]          event_status_nxt;
    logic [15:0]          event_mask_r;
    logic [15:0]          event_mask_nxt;
    logic                 irq_r;

    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    logic                 aw_held_r;
    logic                 w_held_r;
    logic [ADDR_W-1:0]    aw_addr_r;
    logic [31:0]          w_data_r;
    logic [3:0]           w_strb_r;
    logic                 bvalid_r;
    logic [1:0]           bresp_r;

    wire                  aw_take  = s_axi_awvalid_i && s_axi_awready_o;
    wire                  w_take   = s_axi_wvalid_i && s_axi_wready_o;
    wire                  wr_fire  = aw_held_r && w_held_r && !bvalid_r;
    wire                  wr_en    = wr_fire && (aw_addr_r == ieps_pkg::OFF_ENABLE);
    wire                  wr_prio  = wr_fire && (aw_addr_r == ieps_pkg::OFF_PRIORITY);
    wire                  wr_stat  = wr_fire && (aw_addr_r == ieps_pkg::OFF_STATUS);
    wire                  wr_mask  = wr_fire && (aw_addr_r == ieps_pkg::OFF_MASK);
    wire                  wr_hit   = wr_en || wr_prio || wr_stat || wr_mask;

    assign s_axi_awready_o = !aw_held_r && !bvalid_r;
    assign s_axi_wready_o  = !w_held_r && !bvalid_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata_i;
            w_strb_r <= s_axi_wstrb_i;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_r <= 1'b0;
            bresp_r  <= ieps_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? ieps_pkg::RESP_OKAY : ieps_pkg::RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------
    ieps_pkg::ieps_src_t  gated_req;
    logic [15:0]          event_set;

    always_comb begin
        event_set = '0;
        event_set[ieps_pkg::BIT_CAL_EN] = gated_req.calendar;
        event_set[ieps_pkg::BIT_COL_EN] = gated_req.collision;
        event_set[ieps_pkg::BIT_EVT_EN] = gated_req.serial_event;
    end

    assign irq_enable_reg_three_nxt = wr_en ?
        merge_strb(irq_enable_reg_three_r, w_data_r, w_strb_r, ieps_pkg::ENABLE_IMPL) :
        irq_enable_reg_three_r;
    assign irq_priority_reg_fifteen_nxt = wr_prio ?
        merge_strb(irq_priority_reg_fifteen_r, w_data_r, w_strb_r, ieps_pkg::PRIORITY_IMPL) :
        irq_priority_reg_fifteen_r;
    assign event_mask_nxt = wr_mask ?
        merge_strb(event_mask_r, w_data_r, w_strb_r, ieps_pkg::EVENT_IMPL) :
        event_mask_r;
    // Set wins over a same-cycle clear
    assign event_status_nxt = ((event_status_r &
        ~(wr_stat ? w1c_mask(w_data_r, w_strb_r) : 16'h0000)) | event_set)
        & ieps_pkg::EVENT_IMPL;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_enable_reg_three_r     <= ieps_pkg::ENABLE_RST;
            irq_priority_reg_fifteen_r <= ieps_pkg::PRIORITY_RST;
            event_status_r             <= ieps_pkg::EVENT_RST;
            event_mask_r               <= ieps_pkg::EVENT_RST;
            irq_r                      <= 1'b0;
        end else begin
            irq_enable_reg_three_r     <= irq_enable_reg_three_nxt;
            irq_priority_reg_fifteen_r <= irq_priority_reg_fifteen_nxt;
            event_status_r             <= event_status_nxt;
            event_mask_r               <= event_mask_nxt;
            irq_r                      <= |(event_status_nxt & event_mask_nxt);
        end
    end

    assign irq_o = irq_r;

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic                 rvalid_r;
    logic [31:0]          rdata_r;
    logic [1:0]           rresp_r;
    logic [15:0]          rd_word;
    logic                 rd_hit;

    wire                  ar_take = s_axi_arvalid_i && s_axi_arready_o;

    assign s_axi_arready_o = !rvalid_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;

    always_comb begin
        rd_word = 16'h0000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr_i)
            ieps_pkg::OFF_ENABLE:   rd_word = irq_enable_reg_three_r;
            ieps_pkg::OFF_PRIORITY: rd_word = irq_priority_reg_fifteen_r;
            ieps_pkg::OFF_STATUS:   rd_word = event_status_r;
            ieps_pkg::OFF_MASK:     rd_word = event_mask_r;
            default:                rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= ieps_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {16'h0000, rd_word};
            rresp_r  <= rd_hit ? ieps_pkg::RESP_OKAY : ieps_pkg::RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Gating slice
    // ------------------------------------------------------------
    logic [2:0]           cal_prio_field;

    assign cal_prio_field = irq_priority_reg_fifteen_r[ieps_pkg::PRIO_LSB +: ieps_pkg::PRIO_W];

    ieps_gate u_gate (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .src_i      (src_req_i),
        .enable_i   (irq_enable_reg_three_r),
        .cal_prio_i (cal_prio_field),
        .req_o      (gated_req),
        .cal_prio_o (calendar_irq_priority_o)
    );

    assign arb_req_o                     = gated_req;
    assign calendar_irq_enable_o         = irq_enable_reg_three_r[ieps_pkg::BIT_CAL_EN];
    assign serial_collision_irq_enable_o = irq_enable_reg_three_r[ieps_pkg::BIT_COL_EN];
    assign serial_event_irq_enable_o     = irq_enable_reg_three_r[ieps_pkg::BIT_EVT_EN];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_CAL_EN_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && w_strb_r[1]) |=> (irq_enable_reg_three_r[14] == $past(w_data_r[14])))
        else $error("calendar enable bit did not take the written value");

    AST_COL_EN_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && w_strb_r[0]) |=> (irq_enable_reg_three_r[2] == $past(w_data_r[2])))
        else $error("collision enable bit did not take the written value");

    AST_EVT_EN_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && w_strb_r[0]) |=> (irq_enable_reg_three_r[1] == $past(w_data_r[1])))
        else $error("serial event enable bit did not take the written value");

    AST_COL_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> (arb_req_o.collision ==
        $past(src_req_i.collision && irq_enable_reg_three_r[2])))
        else $error("collision request gating wrong");

    AST_EVT_BLOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!irq_enable_reg_three_r[1] && !$past(irq_enable_reg_three_r[1]) && $past(rst_n_i))
        |-> !arb_req_o.serial_event)
        else $error("serial event request passed while disabled");

    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ((irq_enable_reg_three_r & ~ieps_pkg::ENABLE_IMPL) == 16'h0000) &&
        ((irq_priority_reg_fifteen_r & ~ieps_pkg::PRIORITY_IMPL) == 16'h0000) &&
        (!rvalid_r || (rdata_r[31:16] == 16'h0000)))
        else $error("unassigned bits not zero");

    AST_EN_RESET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(rst_n_i) |-> (irq_enable_reg_three_r == 16'h0000))
        else $error("enable register not cleared by reset");

    AST_PRIO_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($past(rst_n_i) && $past(cal_prio_field) == 3'h0) |-> !arb_req_o.calendar)
        else $error("calendar request passed at level zero");

    AST_PRIO_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> (calendar_irq_priority_o == $past(cal_prio_field)))
        else $error("calendar level not presented to arbitration");

    AST_PRIO_RESET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(rst_n_i) |-> (irq_priority_reg_fifteen_r == ieps_pkg::PRIORITY_RST))
        else $error("priority register reset value wrong");

    AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> (irq_o == |$past(event_status_nxt & event_mask_nxt)))
        else $error("interrupt output does not follow masked status");

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_stat && gated_req.collision) |=> event_status_r[2])
        else $error("status event lost under a clear");

    AST_WR_RESP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_fire |=> (bvalid_r &&
        (bresp_r == ($past(wr_hit) ? ieps_pkg::RESP_OKAY : ieps_pkg::RESP_SLVERR))))
        else $error("write response missing");

    AST_CAL_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> (arb_req_o.calendar == $past(src_req_i.calendar &&
        calendar_irq_enable_o && (cal_prio_field != ieps_pkg::PRIO_OFF))))
        else $error("calendar request gating wrong");

    AST_EVT_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> (arb_req_o.serial_event ==
        $past(src_req_i.serial_event && serial_event_irq_enable_o)))
        else $error("serial event request gating wrong");

    AST_EN_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !wr_en |=> $stable(irq_enable_reg_three_r))
        else $error("enable register changed without a write");

    AST_PRIO_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_prio && w_strb_r[1]) |=>
        (cal_prio_field == $past(w_data_r[ieps_pkg::PRIO_LSB +: ieps_pkg::PRIO_W])))
        else $error("calendar level did not take the written value");

    AST_PRIO_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !wr_prio |=> $stable(irq_priority_reg_fifteen_r))
        else $error("priority register changed without a write");

    AST_RD_RESP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ar_take |=> (rvalid_r &&
        (rresp_r == ($past(rd_hit) ? ieps_pkg::RESP_OKAY : ieps_pkg::RESP_SLVERR))))
        else $error("read response wrong");

    AST_RD_ENABLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ar_take && (s_axi_araddr_i == ieps_pkg::OFF_ENABLE)) |=>
        (rdata_r == {16'h0000, $past(irq_enable_reg_three_r)}))
        else $error("enable register read back wrong");

    AST_STAT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_stat && w_strb_r[0] && w_data_r[ieps_pkg::BIT_COL_EN] && !gated_req.collision)
        |=> !event_status_r[ieps_pkg::BIT_COL_EN])
        else $error("status bit not cleared by a write of one");

    AST_BVALID_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (bvalid_r && s_axi_bready_i) |=> !bvalid_r)
        else $error("write response not retired");

    AST_RVALID_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rvalid_r && s_axi_rready_i) |=> !rvalid_r)
        else $error("read response not retired");

endmodule : ieps_top

`default_nettype wire

// file: verification/ieps_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module ieps_top_tb_top;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                clk_i   = 1'b0;
    logic                rst_n_i = 1'b0;
    logic [7:0]          awaddr  = 8'h00;
    logic                awvalid = 1'b0;
    logic [31:0]         wdata   = 32'h0000_0000;
    logic [3:0]          wstrb   = 4'h0;
    logic                wvalid  = 1'b0;
    logic                bready  = 1'b0;
    logic [7:0]          araddr  = 8'h00;
    logic                arvalid = 1'b0;
    logic                rready  = 1'b0;
    ieps_pkg::ieps_src_t src_req = 3'h0;
    logic                awready;
    logic                wready;
    logic [1:0]          bresp;
    logic                bvalid;
    logic                arready;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                rvalid;
    ieps_pkg::ieps_src_t arb_req;
    logic [2:0]          cal_prio;
    logic                cal_en;
    logic                col_en;
    logic                evt_en;
    logic                irq;
    int                  bad_count   = 0;
    int                  comparisons = 0;
    logic [2:0]          ev;

    always #2 clk_i = ~clk_i;

    ieps_top u_dut (
        .clk_i                         (clk_i),
        .rst_n_i                       (rst_n_i),
        .s_axi_awaddr_i                (awaddr),
        .s_axi_awvalid_i               (awvalid),
        .s_axi_awready_o               (awready),
        .s_axi_wdata_i                 (wdata),
        .s_axi_wstrb_i                 (wstrb),
        .s_axi_wvalid_i                (wvalid),
        .s_axi_wready_o                (wready),
        .s_axi_bresp_o                 (bresp),
        .s_axi_bvalid_o                (bvalid),
        .s_axi_bready_i                (bready),
        .s_axi_araddr_i                (araddr),
        .s_axi_arvalid_i               (arvalid),
        .s_axi_arready_o               (arready),
        .s_axi_rdata_o                 (rdata),
        .s_axi_rresp_o                 (rresp),
        .s_axi_rvalid_o                (rvalid),
        .s_axi_rready_i                (rready),
        .src_req_i                     (src_req),
        .arb_req_o                     (arb_req),
        .calendar_irq_priority_o       (cal_prio),
        .calendar_irq_enable_o         (cal_en),
        .serial_collision_irq_enable_o (col_en),
        .serial_event_irq_enable_o     (evt_en),
        .irq_o                         (irq)
    );

    // ------------------------------------------------------------
    // Compare tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: response %h expected %h", $time, got, exp);
        end
    endtask : chk_resp

    task automatic chk_sig(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: output %b expected %b", $time, got, exp);
        end
    endtask : chk_sig

    // ------------------------------------------------------------
    // Bus tasks, ready sampled at the falling edge before each rising edge
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] exp);
        logic aw_p;
        logic w_p;
        logic aw_hit;
        logic w_hit;
        logic b_hit;
        logic [1:0] r;
        aw_p  = 1'b1;
        w_p   = 1'b1;
        b_hit = 1'b0;
        @(posedge clk_i);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!b_hit) begin
            @(negedge clk_i);
            aw_hit = aw_p && (awready === 1'b1);
            w_hit  = w_p && (wready === 1'b1);
            b_hit  = (bvalid === 1'b1);
            r      = bresp;
            @(posedge clk_i);
            if (aw_hit) begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_hit) begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        bready <= 1'b0;
        chk_resp(r, exp);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r);
        logic ar_hit;
        logic r_hit;
        ar_hit = 1'b0;
        r_hit  = 1'b0;
        @(posedge clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!r_hit) begin
            @(negedge clk_i);
            ar_hit = arvalid && (arready === 1'b1);
            r_hit  = (rvalid === 1'b1);
            if (r_hit) begin
                chk_word(rdata, exp);
                chk_resp(rresp, exp_r);
            end
            @(posedge clk_i);
            if (ar_hit) begin
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
    endtask : rd

    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        chk_sig({cal_en, col_en, evt_en}, 3'h0);
        chk_sig(cal_prio, 3'h4);
        chk_sig(arb_req, 3'h0);
    endtask : do_reset

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        #40000;
        bad_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        rd(ieps_pkg::OFF_ENABLE, 32'h0000_0000, ieps_pkg::RESP_OKAY);
        rd(ieps_pkg::OFF_PRIORITY, 32'h0000_0400, ieps_pkg::RESP_OKAY);
        wr(ieps_pkg::OFF_ENABLE, 32'hFFFF_FFFF, 4'hF, ieps_pkg::RESP_OKAY);
        rd(ieps_pkg::OFF_ENABLE, 32'h0000_4006, ieps_pkg::RESP_OKAY);
        wr(ieps_pkg::OFF_ENABLE, 32'h0000_0000, 4'hF, ieps_pkg::RESP_OKAY);
        rd(ieps_pkg::OFF_ENABLE, 32'h0000_0000, ieps_pkg::RESP_OKAY);
        wr(ieps_pkg::OFF_ENABLE, 32'h0000_FFFF, 4'h2, ieps_pkg::RESP_OKAY);
        rd(ieps_pkg::OFF_ENABLE, 32'h0000_4000, ieps_pkg::RESP_OKAY);
        src_req <= 3'h7;
        for (int e = 0; e < 8; e++) begin
            ev = e[2:0];
            wr(ieps_pkg::OFF_ENABLE, {17'h0, ev[2], 11'h0, ev[1:0], 1'b0}, 4'h3,
               ieps_pkg::RESP_OKAY);
            @(posedge clk_i);
            @(negedge clk_i);
            chk_sig({cal_en, col_en, evt_en}, ev);
            chk_sig(arb_req, ev);
        end
        for (int p = 0; p < 8; p++) begin
            ev = p[2:0];
            wr(ieps_pkg::OFF_PRIORITY, {21'h0, ev, 8'h00}, 4'h3, ieps_pkg::RESP_OKAY);
            @(posedge clk_i);
            @(negedge clk_i);
            chk_sig(cal_prio, ev);
            chk_sig(arb_req, {(ev != 3'h0), 2'h3});
        end
        wr(ieps_pkg::OFF_PRIORITY, 32'hFFFF_FFFF, 4'hF, ieps_pkg::RESP_OKAY);
        rd(ieps_pkg::OFF_PRIORITY, 32'h0000_0700, ieps_pkg::RESP_OKAY);
        src_req <= 3'h0;
        repeat (2) @(posedge clk_i);
        wr(ieps_pkg::OFF_STATUS, 32'h0000_FFFF, 4'h3, ieps_pkg::RESP_OKAY);
        rd(ieps_pkg::OFF_STATUS, 32'h0000_0000, ieps_pkg::RESP_OKAY);
        src_req <= 3'h2;
        repeat (3) @(posedge clk_i);
        src_req <= 3'h0;
        rd(ieps_pkg::OFF_STATUS, 32'h0000_0004, ieps_pkg::RESP_OKAY);
        @(negedge clk_i);
        chk_sig({2'h0, irq}, 3'h0);
        wr(ieps_pkg::OFF_MASK, 32'hFFFF_FFFF, 4'hF, ieps_pkg::RESP_OKAY);
        rd(ieps_pkg::OFF_MASK, 32'h0000_4006, ieps_pkg::RESP_OKAY);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk_sig({2'h0, irq}, 3'h1);
        @(posedge clk_i);
        src_req <= 3'h2;
        wr(ieps_pkg::OFF_STATUS, 32'h0000_0004, 4'h1, ieps_pkg::RESP_OKAY);
        rd(ieps_pkg::OFF_STATUS, 32'h0000_0004, ieps_pkg::RESP_OKAY);
        src_req <= 3'h0;
        wr(ieps_pkg::OFF_STATUS, 32'h0000_0004, 4'h1, ieps_pkg::RESP_OKAY);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk_sig({2'h0, irq}, 3'h0);
        wr(8'h10, 32'hFFFF_FFFF, 4'hF, ieps_pkg::RESP_SLVERR);
        rd(8'h10, 32'h0000_0000, ieps_pkg::RESP_SLVERR);
        rd(ieps_pkg::OFF_ENABLE, 32'h0000_4006, ieps_pkg::RESP_OKAY);
        do_reset();
        rd(ieps_pkg::OFF_ENABLE, 32'h0000_0000, ieps_pkg::RESP_OKAY);
        rd(ieps_pkg::OFF_PRIORITY, 32'h0000_0400, ieps_pkg::RESP_OKAY);
        conclude();
    end

endmodule : ieps_top_tb_top

`default_nettype wire
